//--- logic/phc_pkg.sv
// Shared constants, types and functions of the header codec
package phc_pkg;

    // ******************************************
    // Widths and field positions
    // ******************************************
    localparam int PHC_BYTE_W = 8;
    localparam int PHC_DATA_W = 24;
    localparam int PHC_HDR_W = 32;
    localparam int PHC_FIELD_W = 16;
    localparam int PHC_CHAN_W = 2;
    localparam int PHC_FMT_W = 6;
    localparam int PHC_NUM_CHAN = 4;
    localparam int PHC_ID_LSB = 0;
    localparam int PHC_FIELD_LSB = 8;
    localparam int PHC_ECC_LSB = 24;
    localparam int PHC_FOOT_BYTES = 2;
    localparam int PHC_HDR_BYTES = 4;

    // ******************************************
    // Format code classes
    // ******************************************
    localparam logic [5:0] PHC_FMT_FRAME_START = 6'h00;
    localparam logic [5:0] PHC_FMT_FRAME_END = 6'h01;
    localparam logic [5:0] PHC_FMT_LINE_START = 6'h02;
    localparam logic [5:0] PHC_FMT_LINE_END = 6'h03;
    localparam logic [5:0] PHC_FMT_SYNC_MAX = 6'h07;
    localparam logic [5:0] PHC_FMT_SHORT_MAX = 6'h0f;
    localparam logic [5:0] PHC_FMT_LONG_MAX = 6'h37;

    typedef enum logic [2:0] {
        PHC_CLS_FRAME = 3'b000,
        PHC_CLS_LINE = 3'b001,
        PHC_CLS_SYNC_RSVD = 3'b010,
        PHC_CLS_GEN_SHORT = 3'b011,
        PHC_CLS_LONG = 3'b100,
        PHC_CLS_RESERVED = 3'b101
    } phc_class_t;

    typedef enum logic [1:0] {
        PHC_ECC_CLEAN = 2'b00,
        PHC_ECC_FIXED_DATA = 2'b01,
        PHC_ECC_FIXED_PARITY = 2'b10,
        PHC_ECC_FATAL = 2'b11
    } phc_ecc_t;

    // ******************************************
    // Syndrome pattern of each header data bit
    // ******************************************
    localparam logic [7:0] PHC_SYN [0:PHC_DATA_W-1] = '{
        8'h07, 8'h0b, 8'h0d, 8'h0e, 8'h13, 8'h15, 8'h16, 8'h19,
        8'h1a, 8'h1c, 8'h23, 8'h25, 8'h26, 8'h29, 8'h2a, 8'h2c,
        8'h31, 8'h32, 8'h34, 8'h38, 8'h1f, 8'h2f, 8'h37, 8'h3b
    };

    // Bits 7:6 stay zero: no 24-bit pattern uses them
    function automatic logic [7:0] phc_parity(input logic [PHC_DATA_W-1:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < PHC_DATA_W; i++) begin
            if (d[i]) begin
                p = p ^ PHC_SYN[i];
            end
        end
        return p;
    endfunction

    function automatic phc_class_t phc_classify(input logic [PHC_FMT_W-1:0] f);
        phc_class_t c;
        if (f == PHC_FMT_FRAME_START || f == PHC_FMT_FRAME_END) begin
            c = PHC_CLS_FRAME;
        end else if (f == PHC_FMT_LINE_START || f == PHC_FMT_LINE_END) begin
            c = PHC_CLS_LINE;
        end else if (f <= PHC_FMT_SYNC_MAX) begin
            c = PHC_CLS_SYNC_RSVD;
        end else if (f <= PHC_FMT_SHORT_MAX) begin
            c = PHC_CLS_GEN_SHORT;
        end else if (f <= PHC_FMT_LONG_MAX) begin
            c = PHC_CLS_LONG;
        end else begin
            c = PHC_CLS_RESERVED;
        end
        return c;
    endfunction

    function automatic logic [PHC_NUM_CHAN-1:0] phc_route(input logic [PHC_CHAN_W-1:0] ch);
        logic [PHC_NUM_CHAN-1:0] r;
        r = '0;
        r[ch] = 1'b1;
        return r;
    endfunction

endpackage

//--- logic/phc_ecc_check.sv
// Header syndrome decoder with single-bit correction
`timescale 1ns/1ps
`default_nettype none
module phc_ecc_check
    import phc_pkg::*;
(
    input wire logic [PHC_DATA_W-1:0] data_in,
    input wire logic [7:0] ecc_in,
    output logic [PHC_DATA_W-1:0] data_out,
    output logic [7:0] syndrome,
    output phc_ecc_t status
);

    logic hit;

    always_comb begin
        syndrome = phc_parity(data_in) ^ ecc_in;
        data_out = data_in;
        hit = 1'b0;
        for (int i = 0; i < PHC_DATA_W; i++) begin
            if (syndrome == PHC_SYN[i]) begin
                data_out[i] = ~data_in[i];
                hit = 1'b1;
            end
        end
        if (syndrome == 8'h00) begin
            status = PHC_ECC_CLEAN;
        end else if (hit) begin
            status = PHC_ECC_FIXED_DATA;
        end else if ($onehot(syndrome)) begin
            // Parity bit hit; data left as received
            status = PHC_ECC_FIXED_PARITY;
        end else begin
            status = PHC_ECC_FATAL;
        end
    end

endmodule
`default_nettype wire

//--- logic/phc_host.sv
// Link-side controller: sends protected headers, receives and checks packets
//
// How it works
// - Bits go out and come in LSB first
// - Multi-byte fields travel low byte first
// - Codes 0x00-0x0F are short packets
// - Short packet: header only, field replaces count
// - Identifier: channel top two, format low six
// - Six format classes: frame, line, sync, short, long, reserved
// - Correction byte bits 7:6 sent zero
// - Code input: identifier, count low, count high
// - Fixed syndrome pattern per data bit
// - Parity bit XORs its covered data bits
// - Codes 0x10-0x37 are long packets
`timescale 1ns/1ps
`default_nettype none
module phc_host
    import phc_pkg::*;
#(
    parameter int NUM_CHAN = PHC_NUM_CHAN
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [PHC_CHAN_W-1:0] cmd_channel,
    input wire logic [PHC_FMT_W-1:0] cmd_format,
    input wire logic [PHC_FIELD_W-1:0] cmd_field,
    output logic tx_lane_bit,
    output logic tx_lane_active,
    input wire logic rx_lane_bit,
    input wire logic rx_lane_active,
    output logic hdr_valid,
    output logic [PHC_CHAN_W-1:0] hdr_channel,
    output logic [PHC_FMT_W-1:0] hdr_format,
    output logic [PHC_FIELD_W-1:0] hdr_field,
    output phc_class_t hdr_class,
    output phc_ecc_t hdr_ecc_status,
    output logic [7:0] hdr_syndrome,
    output logic [NUM_CHAN-1:0] hdr_route,
    output logic payload_valid,
    output logic [PHC_BYTE_W-1:0] payload_byte,
    output logic [NUM_CHAN-1:0] payload_route,
    output logic footer_valid,
    output logic [PHC_FIELD_W-1:0] footer_word
);

    // ******************************************
    // Transmit path
    // ******************************************
    typedef enum logic {
        PHC_TX_IDLE = 1'b0,
        PHC_TX_SEND = 1'b1
    } phc_tx_state_t;

    localparam logic [4:0] TX_LAST_BIT = 5'(PHC_HDR_W - 1);

    phc_tx_state_t tx_state_q, tx_state_d;
    logic [PHC_HDR_W-1:0] tx_shift_q, tx_shift_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic [PHC_DATA_W-1:0] tx_data;

    assign cmd_ready = (tx_state_q == PHC_TX_IDLE);
    assign tx_lane_bit = tx_shift_q[0];
    assign tx_lane_active = (tx_state_q == PHC_TX_SEND);

    always_comb begin
        tx_state_d = tx_state_q;
        tx_shift_d = tx_shift_q;
        tx_cnt_d = tx_cnt_q;
        // Field low byte first
        tx_data = {cmd_field, cmd_channel, cmd_format};
        case (tx_state_q)
            PHC_TX_IDLE: begin
                if (cmd_valid) begin
                    // Top two parity bits come out zero
                    tx_shift_d = {phc_parity(tx_data), tx_data};
                    tx_cnt_d = '0;
                    tx_state_d = PHC_TX_SEND;
                end
            end
            PHC_TX_SEND: begin
                tx_shift_d = {1'b0, tx_shift_q[PHC_HDR_W-1:1]};
                tx_cnt_d = tx_cnt_q + 5'd1;
                if (tx_cnt_q == TX_LAST_BIT) begin
                    // One idle cycle ends the burst
                    tx_state_d = PHC_TX_IDLE;
                end
            end
            default: begin
                tx_state_d = PHC_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_state_q <= PHC_TX_IDLE;
            tx_shift_q <= '0;
            tx_cnt_q <= '0;
        end else if (ce) begin
            tx_state_q <= tx_state_d;
            tx_shift_q <= tx_shift_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // ******************************************
    // Receive path
    // ******************************************
    typedef enum logic [2:0] {
        PHC_RX_HUNT = 3'b000,
        PHC_RX_HDR = 3'b001,
        PHC_RX_PAY = 3'b010,
        PHC_RX_FOOT = 3'b011,
        PHC_RX_DRAIN = 3'b100
    } phc_rx_state_t;

    localparam logic [2:0] RX_LAST_BIT = 3'(PHC_BYTE_W - 1);
    localparam logic [1:0] RX_LAST_HDR = 2'(PHC_HDR_BYTES - 1);
    localparam logic [1:0] RX_LAST_FOOT = 2'(PHC_FOOT_BYTES - 1);

    phc_rx_state_t rx_state_q, rx_state_d;
    logic rx_prev_q, rx_prev_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [1:0] rx_byte_cnt_q, rx_byte_cnt_d;
    logic [PHC_BYTE_W-1:0] rx_sh_q, rx_sh_d;
    logic [PHC_HDR_W-1:0] rx_hdr_q, rx_hdr_d;
    logic [PHC_FIELD_W-1:0] rx_left_q, rx_left_d;
    logic [PHC_FIELD_W-1:0] foot_q, foot_d;
    logic [PHC_BYTE_W-1:0] rx_byte;
    logic [PHC_HDR_W-1:0] rx_word;
    logic rx_start, rx_take, rx_done;
    logic [PHC_DATA_W-1:0] fixed_data;
    logic [7:0] syn;
    phc_ecc_t ecc_st;
    phc_class_t cls;

    logic hdr_valid_d, payload_valid_d, footer_valid_d;
    logic [PHC_CHAN_W-1:0] hdr_channel_d;
    logic [PHC_FMT_W-1:0] hdr_format_d;
    logic [PHC_FIELD_W-1:0] hdr_field_d;
    phc_class_t hdr_class_d;
    phc_ecc_t hdr_ecc_d;
    logic [7:0] hdr_syn_d;
    logic [PHC_BYTE_W-1:0] payload_byte_d;
    logic [PHC_FIELD_W-1:0] footer_word_d;

    // Received against recomputed parity
    phc_ecc_check u_check (
        .data_in(rx_word[PHC_DATA_W-1:0]),
        .ecc_in(rx_word[PHC_HDR_W-1:PHC_ECC_LSB]),
        .data_out(fixed_data),
        .syndrome(syn),
        .status(ecc_st)
    );

    always_comb begin
        rx_start = rx_lane_active && !rx_prev_q;
        rx_take = (rx_state_q == PHC_RX_HUNT) ? rx_start : rx_lane_active;
        rx_byte = {rx_lane_bit, rx_sh_q[PHC_BYTE_W-1:1]};
        rx_done = rx_take && (rx_bit_q == RX_LAST_BIT);
        rx_word = {rx_byte, rx_hdr_q[PHC_HDR_W-1:PHC_BYTE_W]};
        cls = phc_classify(fixed_data[PHC_FMT_W-1:0]);

        rx_state_d = rx_state_q;
        rx_prev_d = rx_lane_active;
        rx_bit_d = rx_bit_q;
        rx_byte_cnt_d = rx_byte_cnt_q;
        rx_sh_d = rx_sh_q;
        rx_hdr_d = rx_hdr_q;
        rx_left_d = rx_left_q;
        foot_d = foot_q;
        hdr_valid_d = 1'b0;
        payload_valid_d = 1'b0;
        footer_valid_d = 1'b0;
        hdr_channel_d = hdr_channel;
        hdr_format_d = hdr_format;
        hdr_field_d = hdr_field;
        hdr_class_d = hdr_class;
        hdr_ecc_d = hdr_ecc_status;
        hdr_syn_d = hdr_syndrome;
        payload_byte_d = payload_byte;
        footer_word_d = footer_word;

        if (rx_take) begin
            rx_sh_d = rx_byte;
            rx_bit_d = rx_bit_q + 3'd1;
        end

        case (rx_state_q)
            PHC_RX_HUNT: begin
                rx_byte_cnt_d = '0;
                rx_bit_d = rx_start ? 3'd1 : 3'd0;
                if (rx_start) begin
                    rx_state_d = PHC_RX_HDR;
                end
            end
            PHC_RX_HDR: begin
                if (rx_done) begin
                    rx_hdr_d = rx_word;
                    rx_byte_cnt_d = rx_byte_cnt_q + 2'd1;
                    if (rx_byte_cnt_q == RX_LAST_HDR) begin
                        rx_byte_cnt_d = '0;
                        hdr_valid_d = 1'b1;
                        hdr_ecc_d = ecc_st;
                        hdr_syn_d = syn;
                        hdr_channel_d = fixed_data[PHC_FMT_W +: PHC_CHAN_W];
                        hdr_format_d = fixed_data[PHC_FMT_W-1:0];
                        // Word count, frame/line number or user data, delivered as is
                        hdr_field_d = fixed_data[PHC_DATA_W-1:PHC_FIELD_LSB];
                        hdr_class_d = cls;
                        rx_left_d = hdr_field_d;
                        if (ecc_st == PHC_ECC_FATAL) begin
                            // Header untrusted: ignore rest of burst
                            rx_state_d = PHC_RX_DRAIN;
                        end else if (cls != PHC_CLS_LONG) begin
                            rx_state_d = PHC_RX_DRAIN;
                        end else if (hdr_field_d == '0) begin
                            rx_state_d = PHC_RX_FOOT;
                        end else begin
                            rx_state_d = PHC_RX_PAY;
                        end
                    end
                end
            end
            PHC_RX_PAY: begin
                if (rx_done) begin
                    payload_valid_d = 1'b1;
                    payload_byte_d = rx_byte;
                    rx_left_d = rx_left_q - 16'd1;
                    if (rx_left_q == 16'd1) begin
                        rx_state_d = PHC_RX_FOOT;
                    end
                end
            end
            PHC_RX_FOOT: begin
                if (rx_done) begin
                    foot_d = {rx_byte, foot_q[PHC_FIELD_W-1:PHC_BYTE_W]};
                    rx_byte_cnt_d = rx_byte_cnt_q + 2'd1;
                    if (rx_byte_cnt_q == RX_LAST_FOOT) begin
                        footer_valid_d = 1'b1;
                        footer_word_d = foot_d;
                        rx_state_d = PHC_RX_DRAIN;
                    end
                end
            end
            PHC_RX_DRAIN: begin
                rx_bit_d = '0;
            end
            default: begin
                rx_state_d = PHC_RX_HUNT;
            end
        endcase

        // End of burst wins; nothing more is decoded
        if (!rx_lane_active && rx_state_q != PHC_RX_HUNT) begin
            rx_state_d = PHC_RX_HUNT;
            rx_bit_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_state_q <= PHC_RX_HUNT;
            rx_prev_q <= 1'b0;
            rx_bit_q <= '0;
            rx_byte_cnt_q <= '0;
            rx_sh_q <= '0;
            rx_hdr_q <= '0;
            rx_left_q <= '0;
            foot_q <= '0;
            hdr_valid <= 1'b0;
            payload_valid <= 1'b0;
            footer_valid <= 1'b0;
            hdr_channel <= '0;
            hdr_format <= '0;
            hdr_field <= '0;
            hdr_class <= PHC_CLS_FRAME;
            hdr_ecc_status <= PHC_ECC_CLEAN;
            hdr_syndrome <= '0;
            payload_byte <= '0;
            footer_word <= '0;
        end else if (ce) begin
            rx_state_q <= rx_state_d;
            rx_prev_q <= rx_prev_d;
            rx_bit_q <= rx_bit_d;
            rx_byte_cnt_q <= rx_byte_cnt_d;
            rx_sh_q <= rx_sh_d;
            rx_hdr_q <= rx_hdr_d;
            rx_left_q <= rx_left_d;
            foot_q <= foot_d;
            hdr_valid <= hdr_valid_d;
            payload_valid <= payload_valid_d;
            footer_valid <= footer_valid_d;
            hdr_channel <= hdr_channel_d;
            hdr_format <= hdr_format_d;
            hdr_field <= hdr_field_d;
            hdr_class <= hdr_class_d;
            hdr_ecc_status <= hdr_ecc_d;
            hdr_syndrome <= hdr_syn_d;
            payload_byte <= payload_byte_d;
            footer_word <= footer_word_d;
        end
    end

    // ******************************************
    // Channel routing
    // ******************************************
    // Fixed streams; channel remap is left to the far end
    assign hdr_route = hdr_valid ? NUM_CHAN'(phc_route(hdr_channel)) : '0;
    assign payload_route = payload_valid ? NUM_CHAN'(phc_route(hdr_channel)) : '0;

endmodule
`default_nettype wire

//--- test/phc_host_props.sv
// Concurrent property checker for the packet header codec controller
`timescale 1ns/1ps
`default_nettype none
module phc_host_props
    import phc_pkg::*;
#(
    parameter int NUM_CHAN = PHC_NUM_CHAN
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [PHC_CHAN_W-1:0] cmd_channel,
    input wire logic [PHC_FMT_W-1:0] cmd_format,
    input wire logic [PHC_FIELD_W-1:0] cmd_field,
    input wire logic tx_lane_bit,
    input wire logic tx_lane_active,
    input wire logic rx_lane_active,
    input wire logic hdr_valid,
    input wire logic [PHC_CHAN_W-1:0] hdr_channel,
    input wire logic [PHC_FMT_W-1:0] hdr_format,
    input wire phc_class_t hdr_class,
    input wire phc_ecc_t hdr_ecc_status,
    input wire logic [7:0] hdr_syndrome,
    input wire logic [NUM_CHAN-1:0] hdr_route,
    input wire logic payload_valid,
    input wire logic [NUM_CHAN-1:0] payload_route
);
    // ******************************************
    // Burst position counters
    // ******************************************
    logic [5:0] tcnt_d, tcnt_q, rcnt_d, rcnt_q;
    logic [23:0] word_d, word_q;
    always_comb begin
        tcnt_d = tx_lane_active ? tcnt_q + 6'h01 : 6'h00;
        // Saturates: no false second header slot
        rcnt_d = !rx_lane_active ? 6'h00 : (rcnt_q == 6'h3f) ? rcnt_q : rcnt_q + 6'h01;
        word_d = (cmd_valid && cmd_ready) ? {cmd_field, cmd_channel, cmd_format} : word_q;
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tcnt_q <= 6'h00;
            rcnt_q <= 6'h00;
            word_q <= 24'h000000;
        end else if (ce) begin
            tcnt_q <= tcnt_d;
            rcnt_q <= rcnt_d;
            word_q <= word_d;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst || !ce);
    property p_take;
        cmd_valid && cmd_ready |=> tx_lane_active && !cmd_ready;
    endproperty
    a_take: assert property (p_take) else $error("no burst after take");
    property p_busy;
        tx_lane_active |-> !cmd_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_tx_data;
        tx_lane_active && tcnt_q < 6'h18 |-> tx_lane_bit == word_q[tcnt_q[4:0]];
    endproperty
    a_tx_data: assert property (p_tx_data) else $error("wrong header bit");
    property p_tx_top;
        tx_lane_active && tcnt_q >= 6'h1e |-> !tx_lane_bit;
    endproperty
    a_tx_top: assert property (p_tx_top) else $error("top parity bits set");
    property p_tx_len;
        $fell(tx_lane_active) |-> tcnt_q == 6'h20;
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("burst length not 32");
    property p_hdr_time;
        hdr_valid == ($past(rx_lane_active) && $past(rcnt_q) == 6'h1f);
    endproperty
    a_hdr_time: assert property (p_hdr_time) else $error("header pulse misplaced");
    property p_route;
        hdr_route == (hdr_valid ? NUM_CHAN'(1) << hdr_channel : '0)
            && payload_route == (payload_valid ? NUM_CHAN'(1) << hdr_channel : '0);
    endproperty
    a_route: assert property (p_route) else $error("route wrong");
    property p_class;
        hdr_valid |-> (hdr_class == PHC_CLS_LONG) == (hdr_format inside {[6'h10:6'h37]});
    endproperty
    a_class: assert property (p_class) else $error("class wrong");
    property p_status;
        hdr_valid && (hdr_syndrome == 8'h00 || $onehot(hdr_syndrome))
            |-> hdr_ecc_status == (hdr_syndrome == 8'h00 ? PHC_ECC_CLEAN : PHC_ECC_FIXED_PARITY);
    endproperty
    a_status: assert property (p_status) else $error("status wrong");
endmodule
`default_nettype wire

//--- test/phc_link_model.sv
// Far-side link model: sends protected packets, captures sent headers
`timescale 1ns/1ps
`default_nettype none
module phc_link_model
    import phc_pkg::*;
(
    input wire logic core_clk,
    input wire logic tx_lane_bit,
    input wire logic tx_lane_active,
    output logic rx_lane_bit,
    output logic rx_lane_active
);
    // ******************************************
    // Sender and capture
    // ******************************************
    logic busy = 1'b0, drv_bit = 1'b0, idle_bit = 1'b0, tx_was = 1'b0;
    logic [31:0] tx_word = '0, tx_q[$];
    initial rx_lane_active = 1'b0;
    // Released lane toggles so a stale bit never passes for data
    assign rx_lane_bit = busy ? drv_bit : idle_bit;
    always @(negedge core_clk) idle_bit <= ~idle_bit;
    always @(posedge core_clk) begin
        if (tx_lane_active) tx_word <= {tx_lane_bit, tx_word[31:1]};
        if (tx_was && !tx_lane_active) tx_q.push_back(tx_word);
        tx_was <= tx_lane_active;
    end
    function automatic logic [7:0] ecc24(input logic [23:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 24; i++) begin
            if (d[i]) p = p ^ PHC_SYN[i];
        end
        return p;
    endfunction
    // Flip corrupts header bits; nonzero cut aborts early
    task automatic send(input logic [1:0] ch, input logic [5:0] fmt, input logic [15:0] fld,
        input logic [31:0] flip, input int cut, input int gap, input logic [7:0] pay[$]);
        logic [7:0] b[$];
        logic [31:0] h;
        h = {ecc24({fld, ch, fmt}), fld, ch, fmt} ^ flip;
        b = {h[7:0], h[15:8], h[23:16], h[31:24]};
        if (fmt inside {[6'h10:6'h37]}) b = {b, pay, 8'h5a, 8'hc3};
        repeat (gap) @(negedge core_clk);
        for (int i = 0; i < b.size() * 8 && (cut == 0 || i < cut); i++) begin
            @(negedge core_clk);
            busy = 1'b1;
            rx_lane_active = 1'b1;
            drv_bit = b[i / 8][i % 8];
        end
        @(negedge core_clk);
        busy = 1'b0;
        rx_lane_active = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/test_packet_header_ecc_codec.sv
// Self-checking bench of the packet header codec controller
`timescale 1ns/1ps
`default_nettype none
module test_packet_header_ecc_codec
    import phc_pkg::*;
;
    // ******************************************
    // Stimulus and checks
    // ******************************************
    logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, cmd_valid = 1'b0;
    logic [1:0] cmd_channel = '0;
    logic [5:0] cmd_format = '0;
    logic [15:0] cmd_field = '0;
    logic cmd_ready, tx_lane_bit, tx_lane_active, rx_lane_bit, rx_lane_active;
    logic hdr_valid, payload_valid, footer_valid;
    logic [1:0] hdr_channel, ch;
    logic [5:0] hdr_format;
    logic [15:0] hdr_field, footer_word, fld, r, seed = 16'h690b;
    phc_class_t hdr_class, e_cls;
    phc_ecc_t hdr_ecc_status, e_st;
    logic [7:0] hdr_syndrome, payload_byte, e_syn, e_id;
    logic [3:0] hdr_route, payload_route;
    logic [7:0] got_pay[$], pay[$];
    logic [31:0] exp_tx[$], flip;
    logic [5:0] fmts [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h08, 6'h0f, 6'h10, 6'h1c, 6'h37, 6'h38, 6'h3f};
    logic long;
    int fails = 0, checks = 0, hdr_seen = 0, n, a, b2;
    always #25 core_clk = ~core_clk;
    phc_host dut (.core_clk(core_clk), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_channel(cmd_channel), .cmd_format(cmd_format), .cmd_field(cmd_field), .tx_lane_bit(tx_lane_bit),
        .tx_lane_active(tx_lane_active), .rx_lane_bit(rx_lane_bit), .rx_lane_active(rx_lane_active),
        .hdr_valid(hdr_valid), .hdr_channel(hdr_channel), .hdr_format(hdr_format), .hdr_field(hdr_field),
        .hdr_class(hdr_class), .hdr_ecc_status(hdr_ecc_status), .hdr_syndrome(hdr_syndrome),
        .hdr_route(hdr_route), .payload_valid(payload_valid), .payload_byte(payload_byte),
        .payload_route(payload_route), .footer_valid(footer_valid), .footer_word(footer_word));
    phc_link_model lnk (.core_clk(core_clk), .tx_lane_bit(tx_lane_bit), .tx_lane_active(tx_lane_active),
        .rx_lane_bit(rx_lane_bit), .rx_lane_active(rx_lane_active));
    function automatic logic [15:0] rnd();
        seed = {1'b0, seed[15:1]} ^ (seed[0] ? 16'hb400 : 16'h0000);
        return seed;
    endfunction
    function automatic phc_class_t exp_class(input logic [5:0] f);
        if (f < 6'h02) return PHC_CLS_FRAME;
        if (f < 6'h04) return PHC_CLS_LINE;
        if (f < 6'h08) return PHC_CLS_SYNC_RSVD;
        if (f < 6'h10) return PHC_CLS_GEN_SHORT;
        return (f < 6'h38) ? PHC_CLS_LONG : PHC_CLS_RESERVED;
    endfunction
    function automatic phc_ecc_t exp_status(input logic [7:0] s);
        phc_ecc_t t;
        t = (s == 8'h00) ? PHC_ECC_CLEAN : $onehot(s) ? PHC_ECC_FIXED_PARITY : PHC_ECC_FATAL;
        for (int i = 0; i < 24; i++) begin
            if (s == PHC_SYN[i]) t = PHC_ECC_FIXED_DATA;
        end
        return t;
    endfunction
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic send_cmd(input logic [1:0] c, input logic [5:0] f, input logic [15:0] d);
        int k = 0;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_channel = c;
        cmd_format = f;
        cmd_field = d;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask
    always @(negedge core_clk) begin
        if (hdr_valid === 1'b1) begin
            hdr_seen++;
            check("syndrome", hdr_syndrome, e_syn);
            check("status", hdr_ecc_status, e_st);
            if (e_st != PHC_ECC_FATAL) begin
                check("class", hdr_class, e_cls);
                check("identifier", {hdr_channel, hdr_format}, e_id);
                check("field", hdr_field, fld);
            end
        end
        if (payload_valid === 1'b1) got_pay.push_back(payload_byte);
        if (footer_valid === 1'b1) check("footer", footer_word, 16'hc35a);
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        check("ready after reset", cmd_ready, 1'b1);
        check("idle after reset", tx_lane_active, 1'b0);
        // Corner fields, then random, back to back
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            fld = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : rnd();
            exp_tx.push_back({lnk.ecc24({fld, r[7:0]}), fld, r[7:0]});
            send_cmd(r[7:6], r[5:0], fld);
        end
        repeat (36) @(negedge core_clk);
        check("sent count", lnk.tx_q.size(), 8);
        foreach (exp_tx[i]) check("sent header", lnk.tx_q[i], exp_tx[i]);
        // Cut burst yields no header
        lnk.send(2'h1, 6'h10, 16'h0003, '0, 13, 1, pay);
        repeat (2) @(negedge core_clk);
        check("aborted burst", hdr_seen, 0);
        foreach (fmts[j]) begin
            for (int e = 0; e < 4; e++) begin
                r = rnd();
                ch = r[9:8];
                long = fmts[j] inside {[6'h10:6'h37]};
                fld = long ? {14'h0000, r[1:0]} : rnd();
                pay = {};
                for (int i = 0; long && i < fld; i++) begin
                    r = rnd();
                    pay.push_back(r[7:0]);
                end
                a = rnd() % 24;
                b2 = (a + 1 + rnd() % 23) % 24;
                flip = (e == 1) ? 32'h1 << a : (e == 2) ? 32'h1 << (24 + a % 6) : 32'h0;
                if (e == 3) flip = (32'h1 << a) | (32'h1 << b2);
                e_id = {ch, fmts[j]};
                e_cls = exp_class(fmts[j]);
                e_syn = lnk.ecc24({fld, e_id}) ^ flip[31:24] ^ lnk.ecc24({fld, e_id} ^ flip[23:0]);
                e_st = exp_status(e_syn);
                n = hdr_seen;
                lnk.send(ch, fmts[j], fld, flip, 0, 1 + 4 * (e % 2), pay);
                repeat (2) @(negedge core_clk);
                check("header count", hdr_seen - n, 1);
                if (!long || e_st == PHC_ECC_FATAL) pay = {};
                check("payload count", got_pay.size(), pay.size());
                foreach (pay[i]) check("payload", got_pay[i], pay[i]);
                got_pay = {};
            end
        end
        wrap_up();
    end
endmodule
bind phc_host phc_host_props #(.NUM_CHAN(NUM_CHAN)) u_props (.core_clk(core_clk), .srst(srst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_channel(cmd_channel), .cmd_format(cmd_format),
    .cmd_field(cmd_field), .tx_lane_bit(tx_lane_bit), .tx_lane_active(tx_lane_active),
    .rx_lane_active(rx_lane_active), .hdr_valid(hdr_valid), .hdr_channel(hdr_channel),
    .hdr_format(hdr_format), .hdr_class(hdr_class), .hdr_ecc_status(hdr_ecc_status),
    .hdr_syndrome(hdr_syndrome), .hdr_route(hdr_route), .payload_valid(payload_valid),
    .payload_route(payload_route));
`default_nettype wire
